// *** shared/msh_defs.svh ***
`ifndef MSH_DEFS_SVH
`define MSH_DEFS_SVH
// Register addresses
`define MSH_ADDR_MODE_SUPPLY 7'h01
`define MSH_ADDR_HARDWARE_CONTROL 7'h02
// Reset, restart-keep and writable masks
`define MSH_MS_RST 8'h00
`define MSH_HW_RST 8'h00
`define MSH_MS_KEEP 8'h07
`define MSH_HW_KEEP 8'hdf
`define MSH_MS_WMASK 8'hdf
`define MSH_HW_WMASK 8'hff
// Mode/supply fields
`define MSH_MODE_HI 7
`define MSH_MODE_LO 6
`define MSH_AUX_HI 4
`define MSH_AUX_LO 3
`define MSH_OV_RST 2
`define MSH_RT_HI 1
`define MSH_RT_LO 0
// Mode codes and undervoltage-off threshold code
`define MSH_MODE_NORMAL 2'h0
`define MSH_MODE_SLEEP 2'h1
`define MSH_MODE_STOP 2'h2
`define MSH_MODE_SOFT_RST 2'h3
`define MSH_RT_UV_OFF 2'h3
// Hardware control fields
`define MSH_HW_FS_PIN 7
`define MSH_HW_LAG 6
`define MSH_HW_FO_FORCE 5
`define MSH_HW_WK_SEL 4
`define MSH_HW_AUTO 3
`define MSH_HW_BST_V 2
`define MSH_HW_BST_EN 1
`define MSH_HW_FO_CFG 0
// Serial frame
`define MSH_FRAME_BITS 5'd16
`define MSH_ADDR_BITS 5'd8
// Timing
`define MSH_CLK_MHZ 250
`define MSH_LAG_SHORT_US 100
`define MSH_LAG_LONG_US 1000
`define MSH_WD_FAIL_LIMIT 2'd2
`endif

// *** shared/msh_pkg.sv ***
package msh_pkg;
   typedef struct packed {
      logic [6:0] addr;
      logic wr;
      logic [7:0] data;
   } msh_cmd_type;
   typedef enum logic [4:0] {
      MSH_DEV_NORMAL = 5'b00001,
      MSH_DEV_STOP = 5'b00010,
      MSH_DEV_SLEEP = 5'b00100,
      MSH_DEV_RESTART = 5'b01000,
      MSH_DEV_FAILSAFE = 5'b10000
   } msh_dev_state_type;
   typedef enum logic [2:0] {
      MSH_BUCK_PWM = 3'b001,
      MSH_BUCK_LAG = 3'b010,
      MSH_BUCK_PFM = 3'b100
   } msh_buck_state_type;
   typedef struct packed {
      logic aux_on;
      logic uv_reset_en;
      logic [1:0] uv_level;
      logic boost_en;
      logic boost_low_level;
      logic boost_on;
      logic buck_pwm;
   } msh_supply_ctl_type;
   typedef struct packed {
      logic failsafe_input_en;
      logic [1:0] fail_output_pins;
      logic failsafe_req;
   } msh_fail_ctl_type;
endpackage

// *** test/msh_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module msh_host_model (
   // Clock
   input wire logic clock_i,
   // Serial pins
   output logic csn_o,
   output logic sclk_o,
   output logic sdi_o,
   input wire logic sdo_i
);
   initial begin
      csn_o = 1'b1;
      sclk_o = 1'b0;
      sdi_o = 1'b0;
   end
   // Each serial clock phase lasts 3 clocks; response bit k is taken before rise k
   task automatic frame(input logic [15:0] s, input int n, output logic [15:0] r);
      r = 16'h0000;
      @(negedge clock_i);
      csn_o = 1'b0;
      for (int k = 0; k < n; k++) begin
         sdi_o = s[k];
         repeat (3) @(negedge clock_i);
         r[k] = sdo_i;
         sclk_o = 1'b1;
         repeat (3) @(negedge clock_i);
         sclk_o = 1'b0;
      end
      repeat (3) @(negedge clock_i);
      csn_o = 1'b1;
      // Released data line shows no stale level
      sdi_o = ~sdi_o;
      repeat (4) @(negedge clock_i);
   endtask
endmodule
`default_nettype wire

// *** test/msh_mode_supply_hw_control_regs_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module msh_mode_supply_hw_control_regs_test import msh_pkg::*;;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   wire logic csn_i, sclk_i, sdi_i;
   logic sdo_o;
   logic [7:0] status_info_i = 8'ha5;
   msh_dev_state_type dev_state_i = MSH_DEV_NORMAL;
   logic restart_entry_i = 1'b0;
   logic wake_src_enabled_i = 1'b1;
   logic main_ov_i = 1'b0;
   logic wake_pin_i = 1'b0;
   logic battery_low_i = 1'b0;
   logic wd_fail_i = 1'b0;
   logic heavy_load_i = 1'b0;
   logic light_load_i = 1'b0;
   logic [7:0] mode_supply_o, hardware_control_o;
   msh_supply_ctl_type supply_ctl_o;
   msh_fail_ctl_type fail_ctl_o;
   logic restart_req_o, soft_reset_o;
   logic [15:0] rsp;
   int err_total = 0;
   int check_count = 0;
   int rr_cnt = 0;
   int sr_cnt = 0;
   int r0;
   logic [1:0] sc;
   always #2 clock_i = ~clock_i;
   always @(posedge clock_i) begin
      if (restart_req_o === 1'b1) rr_cnt++;
      if (soft_reset_o === 1'b1) sr_cnt++;
   end
   msh_mode_supply_hw_control_regs #(.LAG_SHORT_CYC(10), .LAG_LONG_CYC(40))
      msh_mode_supply_hw_control_regs_inst (.clock_i, .rst_n_i, .csn_i, .sclk_i, .sdi_i,
      .sdo_o, .status_info_i, .dev_state_i, .restart_entry_i, .wake_src_enabled_i,
      .main_ov_i, .wd_fail_i, .failure_i(1'b0), .cfg_strap_i(1'b0), .wake_pin_i,
      .heavy_load_i, .light_load_i, .battery_low_i, .mode_supply_o,
      .hardware_control_o, .supply_ctl_o, .fail_ctl_o, .restart_req_o, .soft_reset_o);
   msh_host_model msh_host_model_inst (.clock_i, .csn_o(csn_i), .sclk_o(sclk_i),
      .sdi_o(sdi_i), .sdo_i(sdo_o));
   // ****
   // Tasks
   // ****
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] d, input int n);
      msh_host_model_inst.frame({d, w, a}, n, rsp);
      repeat (3) @(negedge clock_i);
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(negedge clock_i);
   endtask
   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #50000;
      err_total++;
      end_sim;
   end
   // ****
   // Tests
   // ****
   initial begin
      wait_clk(6);
      rst_n_i = 1'b1;
      wait_clk(2);
      check(mode_supply_o, 8'h00);
      check(hardware_control_o, 8'h00);
      xfer(7'h01, 1'b1, 8'h3f, 16);
      check(rsp[7:0], 8'ha5);
      check(rsp[15:8], 8'h00);
      check(mode_supply_o, 8'h1f);
      xfer(7'h01, 1'b0, 8'h00, 16);
      check(rsp[15:8], 8'h1f);
      check(mode_supply_o, 8'h1f);
      xfer(7'h02, 1'b1, 8'hff, 15);
      check(hardware_control_o, 8'h00);
      xfer(7'h02, 1'b1, 8'hff, 16);
      check(hardware_control_o, 8'hff);
      xfer(7'h03, 1'b1, 8'h00, 16);
      check(rsp[15:8], 8'h00);
      check(hardware_control_o, 8'hff);
      restart_entry_i = 1'b1;
      wait_clk(1);
      restart_entry_i = 1'b0;
      wait_clk(2);
      check(mode_supply_o, 8'h07);
      check(hardware_control_o, 8'hdf);
      dev_state_i = MSH_DEV_SLEEP;
      xfer(7'h02, 1'b1, 8'h00, 16);
      check(hardware_control_o, 8'hdf);
      dev_state_i = MSH_DEV_NORMAL;
      wake_src_enabled_i = 1'b0;
      r0 = rr_cnt;
      xfer(7'h01, 1'b1, 8'h40, 16);
      check({7'h00, rr_cnt > r0}, 8'h01);
      wake_src_enabled_i = 1'b1;
      for (int ov = 1; ov >= 0; ov--) begin
         xfer(7'h01, 1'b1, {5'h00, ov[0], 2'h0}, 16);
         r0 = rr_cnt;
         main_ov_i = 1'b1;
         wait_clk(2);
         main_ov_i = 1'b0;
         wait_clk(2);
         check({7'h00, rr_cnt > r0}, {7'h00, ov[0]});
      end
      r0 = sr_cnt;
      xfer(7'h01, 1'b1, 8'hc0, 16);
      check({7'h00, sr_cnt > r0}, 8'h01);
      check(mode_supply_o, 8'h00);
      check(hardware_control_o, 8'h00);
      for (int i = 0; i < 4; i++) begin
         sc = i[1:0];
         xfer(7'h01, 1'b1, {3'h0, sc, 1'b0, sc}, 16);
         check({7'h00, supply_ctl_o.uv_reset_en}, {7'h00, sc != 2'h3});
         dev_state_i = MSH_DEV_STOP;
         wait_clk(2);
         check({7'h00, supply_ctl_o.aux_on}, {7'h00, sc[1]});
         dev_state_i = MSH_DEV_SLEEP;
         wait_clk(2);
         check({7'h00, supply_ctl_o.aux_on}, {7'h00, sc == 2'h3});
         dev_state_i = MSH_DEV_NORMAL;
         wait_clk(2);
         check({7'h00, supply_ctl_o.aux_on}, {7'h00, sc != 2'h0});
      end
      battery_low_i = 1'b1;
      xfer(7'h02, 1'b1, 8'ha2, 16);
      check({7'h00, supply_ctl_o.boost_on}, 8'h01);
      check({6'h00, fail_ctl_o.fail_output_pins}, 8'h03);
      check({7'h00, fail_ctl_o.failsafe_input_en}, 8'h00);
      xfer(7'h02, 1'b1, 8'h10, 16);
      dev_state_i = MSH_DEV_STOP;
      for (int w = 1; w >= 0; w--) begin
         wake_pin_i = w[0];
         wait_clk(2);
         check({7'h00, supply_ctl_o.buck_pwm}, {7'h00, w[0]});
      end
      dev_state_i = MSH_DEV_NORMAL;
      wait_clk(2);
      // First watchdog fail only counts; the second latches the outputs
      wd_fail_i = 1'b1;
      wait_clk(1);
      check({7'h00, fail_ctl_o.failsafe_req}, 8'h00);
      wd_fail_i = 1'b0;
      wait_clk(2);
      check({6'h00, fail_ctl_o.fail_output_pins}, 8'h00);
      wd_fail_i = 1'b1;
      wait_clk(1);
      wd_fail_i = 1'b0;
      wait_clk(2);
      check({6'h00, fail_ctl_o.fail_output_pins}, 8'h01);
      xfer(7'h02, 1'b1, 8'h08, 16);
      dev_state_i = MSH_DEV_STOP;
      heavy_load_i = 1'b1;
      wait_clk(1);
      heavy_load_i = 1'b0;
      wait_clk(2);
      check({7'h00, supply_ctl_o.buck_pwm}, 8'h01);
      xfer(7'h01, 1'b1, 8'h80, 16);
      check({7'h00, supply_ctl_o.buck_pwm}, 8'h00);
      dev_state_i = MSH_DEV_NORMAL;
      // Lag counts are 10 and 40 here, plus two cycles of pipeline
      for (int lg = 0; lg < 2; lg++) begin
         xfer(7'h02, 1'b1, {1'b0, lg[0], 6'h00}, 16);
         light_load_i = 1'b1;
         wait_clk(lg ? 30 : 8);
         check({7'h00, supply_ctl_o.buck_pwm}, 8'h01);
         wait_clk(lg ? 20 : 6);
         check({7'h00, supply_ctl_o.buck_pwm}, 8'h00);
         light_load_i = 1'b0;
         wait_clk(2);
      end
      end_sim;
   end
endmodule
`default_nettype wire

// *** test/msh_regs_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module msh_regs_chk import msh_pkg::*; (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Watched inputs
   input wire logic csn_i,
   input wire logic restart_entry_i,
   input wire msh_dev_state_type dev_state_i,
   input wire logic main_ov_i,
   input wire logic wake_pin_i,
   input wire logic battery_low_i,
   // Watched outputs
   input wire logic [7:0] mode_supply_o,
   input wire logic [7:0] hardware_control_o,
   input wire msh_supply_ctl_type supply_ctl_o,
   input wire msh_fail_ctl_type fail_ctl_o,
   input wire logic restart_req_o,
   input wire logic soft_reset_o
);
   function automatic logic aux_exp(input msh_dev_state_type s, input logic [1:0] sc);
      return (s == MSH_DEV_NORMAL) ? (sc != 2'h0) :
         (s == MSH_DEV_STOP) ? sc[1] : (s == MSH_DEV_SLEEP) && (sc == 2'h3);
   endfunction
   // ****
   // Assertions
   // ****
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   AST_RESERVED_ZERO: assert property (mode_supply_o[5] == 1'b0)
      else $error("Reserved bit reads one");
   AST_RESTART_MS: assert property (restart_entry_i |=>
      mode_supply_o == ($past(mode_supply_o) & 8'h07)) else $error("Restart mode value wrong");
   AST_RESTART_HW: assert property (restart_entry_i |=>
      hardware_control_o == ($past(hardware_control_o) & 8'hdf)) else $error("Restart hw wrong");
   AST_SOFT_RST: assert property (soft_reset_o |=>
      mode_supply_o == 8'h00 && hardware_control_o == 8'h00) else $error("Soft reset not clean");
   // Mid-frame with no restart nearby the register must hold still
   AST_NO_SELF_CHANGE: assert property (!csn_i && !$past(csn_i) && !$past(csn_i, 2) &&
      !$past(csn_i, 3) && !$past(restart_entry_i) && !$past(restart_entry_i, 2) |->
      $stable(hardware_control_o) && $stable(mode_supply_o)) else $error("Self change");
   AST_AUX_SCOPE: assert property ($past(rst_n_i) |-> supply_ctl_o.aux_on ==
      aux_exp($past(dev_state_i), $past(mode_supply_o[4:3]))) else $error("Aux scope wrong");
   AST_UV_EN: assert property ($past(rst_n_i) |-> supply_ctl_o.uv_reset_en ==
      ($past(mode_supply_o[1:0]) != 2'h3)) else $error("Undervoltage enable wrong");
   AST_OV_RESTART: assert property (main_ov_i && mode_supply_o[2] |=> restart_req_o)
      else $error("Overvoltage did not restart");
   AST_BOOST_ON: assert property ($past(rst_n_i) |-> supply_ctl_o.boost_on ==
      ($past(hardware_control_o[1]) && $past(battery_low_i))) else $error("Boost wrong");
   AST_FAIL_FORCE: assert property ($past(rst_n_i) && $past(hardware_control_o[5]) |->
      fail_ctl_o.fail_output_pins[0]) else $error("Forced fail output missing");
   AST_SHARED_PIN: assert property ($past(rst_n_i) |->
      fail_ctl_o.failsafe_input_en == !$past(hardware_control_o[7]) &&
      (!fail_ctl_o.fail_output_pins[1] || $past(hardware_control_o[7])))
      else $error("Shared pin use wrong");
   AST_STOP_WAKE: assert property ($past(rst_n_i) && $past(dev_state_i) == MSH_DEV_STOP &&
      $past(hardware_control_o[4]) |-> supply_ctl_o.buck_pwm == $past(wake_pin_i))
      else $error("Stop buck select wrong");
endmodule
bind msh_mode_supply_hw_control_regs msh_regs_chk msh_regs_chk_inst (.clock_i, .rst_n_i,
   .csn_i, .restart_entry_i, .dev_state_i, .main_ov_i, .wake_pin_i, .battery_low_i,
   .mode_supply_o, .hardware_control_o, .supply_ctl_o, .fail_ctl_o, .restart_req_o,
   .soft_reset_o);
`default_nettype wire

// *** verilog/msh_mode_supply_hw_control_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "msh_defs.svh"
// Contract
// RL1 - POR or soft reset loads defaults
// RL2 - Restart loads restart values, x kept
// RL3 - Sixteen-bit frame: address, access, data
// RL4 - Read-only ignore writes; rw stores
// RL5 - Access bit 7: 0 read, 1 write
// RL6 - Device never changes control bits itself
// RL7 - Mode field; 11 gives quiet soft reset
// RL8 - Restart clears mode/supply upper five bits
// RL9 - Reserved bit 5 reads zero
// RL10 - Aux regulator scope by mode
// RL11 - Overvoltage reset enable triggers restart
// RL12 - Undervoltage threshold select, 11 disables
// RL13 - Sleep without wake source restarts
// RL14 - Restart clears fail output force
// RL15 - Bit 7 picks fail input or output
// RL16 - Bit 6 picks PWM-to-PFM lag
// RL17 - Bit 5 forces fail outputs
// RL18 - Stop mode: wake pin picks PWM
// RL19 - Auto PWM under load until stop
// RL20 - Boost level and enable
// RL21 - Bit 0 clear: fail after second fail
// RL22 - Strap decides fail-safe on watchdog fail
// RL23 - New setting visible next frame only
// RL24 - Ignore frames in restart/sleep/fail-safe
// RL25 - Reserved bit write discarded
module msh_mode_supply_hw_control_regs import msh_pkg::*; #(
   parameter int unsigned LAG_SHORT_CYC = `MSH_LAG_SHORT_US * `MSH_CLK_MHZ,
   parameter int unsigned LAG_LONG_CYC = `MSH_LAG_LONG_US * `MSH_CLK_MHZ
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Serial port
   input wire logic csn_i,
   input wire logic sclk_i,
   input wire logic sdi_i,
   output logic sdo_o,
   input wire logic [7:0] status_info_i,
   // Device state and events
   input wire msh_dev_state_type dev_state_i,
   input wire logic restart_entry_i,
   input wire logic wake_src_enabled_i,
   input wire logic main_ov_i,
   input wire logic wd_fail_i,
   input wire logic failure_i,
   input wire logic cfg_strap_i,
   input wire logic wake_pin_i,
   input wire logic heavy_load_i,
   input wire logic light_load_i,
   input wire logic battery_low_i,
   // Register content
   output logic [7:0] mode_supply_o,
   output logic [7:0] hardware_control_o,
   // Controls
   output msh_supply_ctl_type supply_ctl_o,
   output msh_fail_ctl_type fail_ctl_o,
   output logic restart_req_o,
   output logic soft_reset_o
);
   localparam int unsigned CW = 18;

   if (LAG_SHORT_CYC < 1 || LAG_LONG_CYC < LAG_SHORT_CYC || LAG_LONG_CYC >= (1 << CW))
   begin : g_chk
      $error("Lag counts out of range");
   end

   function automatic logic aux_on(input logic [1:0] scope, input msh_dev_state_type st);
      case (st)
         MSH_DEV_NORMAL: aux_on = (scope != 2'h0);
         MSH_DEV_STOP: aux_on = scope[1];
         MSH_DEV_SLEEP: aux_on = (scope == 2'h3);
         default: aux_on = 1'b0;
      endcase
   endfunction

   // ****************************************
   // Serial frame and decode
   // ****************************************
   logic accept;
   logic [6:0] rd_addr;
   logic rd_addr_valid;
   msh_cmd_type cmd;
   logic cmd_valid;
   logic [7:0] ms_q, hw_q;
   logic [7:0] rd_data;
   logic wr_ms, wr_hw, soft_rst, load_por, stop_cmd, sleep_bad;

   // Frames count only in normal and stop
   assign accept = (dev_state_i == MSH_DEV_NORMAL) || (dev_state_i == MSH_DEV_STOP); // RL24

   msh_spi_frame u_frame (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .csn_i(csn_i),
      .sclk_i(sclk_i),
      .sdi_i(sdi_i),
      .sdo_o(sdo_o),
      .enable_i(accept),
      .status_i(status_info_i),
      .rd_data_i(rd_data),
      .addr_o(rd_addr),
      .addr_valid_o(rd_addr_valid),
      .cmd_o(cmd),
      .cmd_valid_o(cmd_valid)
   );

   always_comb begin
      case (rd_addr)
         `MSH_ADDR_MODE_SUPPLY: rd_data = ms_q;
         `MSH_ADDR_HARDWARE_CONTROL: rd_data = hw_q;
         default: rd_data = 8'h00;
      endcase
      wr_ms = cmd_valid && cmd.wr && (cmd.addr == `MSH_ADDR_MODE_SUPPLY); // RL5
      wr_hw = cmd_valid && cmd.wr && (cmd.addr == `MSH_ADDR_HARDWARE_CONTROL); // RL5
      soft_rst = wr_ms && (cmd.data[`MSH_MODE_HI:`MSH_MODE_LO] == `MSH_MODE_SOFT_RST); // RL7
      stop_cmd = wr_ms && (cmd.data[`MSH_MODE_HI:`MSH_MODE_LO] == `MSH_MODE_STOP);
      sleep_bad = wr_ms && !wake_src_enabled_i
         && (cmd.data[`MSH_MODE_HI:`MSH_MODE_LO] == `MSH_MODE_SLEEP); // RL13
      load_por = soft_rst; // RL1
   end

   // ****************************************
   // Register bytes
   // ****************************************
   // Only writes, restart and reset alter the bytes
   msh_reg_byte #(
      .RST_VAL(`MSH_MS_RST),
      .KEEP_MASK(`MSH_MS_KEEP),
      .WR_MASK(`MSH_MS_WMASK)
   ) u_ms (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .load_por_i(load_por),
      .load_restart_i(restart_entry_i), // RL8
      .wr_en_i(wr_ms), // RL6
      .wr_data_i(cmd.data), // RL25
      .q_o(ms_q) // RL9
   );

   msh_reg_byte #(
      .RST_VAL(`MSH_HW_RST),
      .KEEP_MASK(`MSH_HW_KEEP),
      .WR_MASK(`MSH_HW_WMASK)
   ) u_hw (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .load_por_i(load_por),
      .load_restart_i(restart_entry_i), // RL14
      .wr_en_i(wr_hw), // RL6
      .wr_data_i(cmd.data),
      .q_o(hw_q)
   );

   assign mode_supply_o = ms_q;
   assign hardware_control_o = hw_q;

   // ****************************************
   // Buck converter mode
   // ****************************************
   msh_buck_state_type buck_r, buck_nxt;
   logic [CW-1:0] lag_cnt_r, lag_cnt_nxt;
   logic auto_pwm_r, auto_pwm_nxt;
   logic [CW-1:0] lag_lim;
   logic buck_pwm;

   always_comb begin
      lag_lim = hw_q[`MSH_HW_LAG] ? CW'(LAG_LONG_CYC - 1) : CW'(LAG_SHORT_CYC - 1); // RL16
      buck_nxt = buck_r;
      lag_cnt_nxt = lag_cnt_r;
      case (buck_r)
         MSH_BUCK_PWM: begin
            lag_cnt_nxt = '0;
            if (light_load_i) begin
               buck_nxt = MSH_BUCK_LAG;
            end
         end
         MSH_BUCK_LAG: begin
            lag_cnt_nxt = lag_cnt_r + CW'(1);
            if (!light_load_i) begin
               buck_nxt = MSH_BUCK_PWM;
            end else if (lag_cnt_r >= lag_lim) begin
               buck_nxt = MSH_BUCK_PFM; // RL16
            end
         end
         MSH_BUCK_PFM: begin
            if (!light_load_i) begin
               buck_nxt = MSH_BUCK_PWM;
            end
         end
         default: buck_nxt = MSH_BUCK_PWM;
      endcase
      // Load event beats a same-cycle stop command
      auto_pwm_nxt = auto_pwm_r;
      if (stop_cmd) begin
         auto_pwm_nxt = 1'b0; // RL19
      end
      if (dev_state_i == MSH_DEV_STOP && hw_q[`MSH_HW_AUTO] && heavy_load_i) begin
         auto_pwm_nxt = 1'b1; // RL19
      end
      case (dev_state_i)
         MSH_DEV_NORMAL: buck_pwm = (buck_r != MSH_BUCK_PFM);
         MSH_DEV_STOP: begin
            if (hw_q[`MSH_HW_WK_SEL]) begin
               buck_pwm = wake_pin_i; // RL18
            end else begin
               buck_pwm = hw_q[`MSH_HW_AUTO] && auto_pwm_r; // RL18
            end
         end
         default: buck_pwm = 1'b0;
      endcase
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         buck_r <= MSH_BUCK_PWM;
         lag_cnt_r <= '0;
         auto_pwm_r <= 1'b0;
      end else begin
         buck_r <= buck_nxt;
         lag_cnt_r <= lag_cnt_nxt;
         auto_pwm_r <= auto_pwm_nxt;
      end
   end

   // ****************************************
   // Fail outputs, strap and reset requests
   // ****************************************
   logic [1:0] wd_cnt_r, wd_cnt_nxt;
   logic fo_latch_r, fo_latch_nxt;
   logic strap_r, strap_nxt;
   logic strap_taken_r, strap_taken_nxt;
   logic restart_r, restart_nxt;
   logic soft_rst_r, soft_rst_nxt;
   msh_supply_ctl_type supply_r, supply_nxt;
   msh_fail_ctl_type fail_r, fail_nxt;
   logic fail_output_force;

   always_comb begin
      // Strap is caught on the first edge after reset release
      strap_taken_nxt = 1'b1;
      strap_nxt = strap_taken_r ? strap_r : cfg_strap_i; // RL22
      wd_cnt_nxt = wd_cnt_r;
      if (load_por) begin
         wd_cnt_nxt = 2'd0;
      end else if (wd_fail_i && wd_cnt_r != `MSH_WD_FAIL_LIMIT) begin
         wd_cnt_nxt = wd_cnt_r + 2'd1;
      end
      // Once triggered, fail outputs hold until reset
      fo_latch_nxt = fo_latch_r || failure_i;
      if (wd_fail_i && !hw_q[`MSH_HW_FO_CFG] && wd_cnt_r == `MSH_WD_FAIL_LIMIT - 2'd1) begin
         fo_latch_nxt = 1'b1; // RL21
      end
      if (wd_fail_i && hw_q[`MSH_HW_FO_CFG]) begin
         fo_latch_nxt = 1'b1;
      end
      fail_output_force = hw_q[`MSH_HW_FO_FORCE] || fo_latch_r; // RL17
      fail_nxt.failsafe_input_en = !hw_q[`MSH_HW_FS_PIN]; // RL15
      fail_nxt.fail_output_pins = {hw_q[`MSH_HW_FS_PIN] && fail_output_force, fail_output_force}; // RL15
      fail_nxt.failsafe_req = wd_fail_i && strap_r; // RL22
      supply_nxt.aux_on = aux_on(ms_q[`MSH_AUX_HI:`MSH_AUX_LO], dev_state_i); // RL10
      supply_nxt.uv_reset_en = (ms_q[`MSH_RT_HI:`MSH_RT_LO] != `MSH_RT_UV_OFF); // RL12
      supply_nxt.uv_level = ms_q[`MSH_RT_HI:`MSH_RT_LO]; // RL12
      supply_nxt.boost_en = hw_q[`MSH_HW_BST_EN]; // RL20
      supply_nxt.boost_low_level = hw_q[`MSH_HW_BST_V]; // RL20
      supply_nxt.boost_on = hw_q[`MSH_HW_BST_EN] && battery_low_i; // RL20
      supply_nxt.buck_pwm = buck_pwm;
      restart_nxt = (main_ov_i && ms_q[`MSH_OV_RST]) || sleep_bad; // RL11
      // Soft reset never requests the reset pin
      soft_rst_nxt = soft_rst; // RL7
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wd_cnt_r <= 2'd0;
         fo_latch_r <= 1'b0;
         strap_r <= 1'b0;
         strap_taken_r <= 1'b0;
         restart_r <= 1'b0;
         soft_rst_r <= 1'b0;
         supply_r <= '0;
         fail_r <= '0;
      end else begin
         wd_cnt_r <= wd_cnt_nxt;
         fo_latch_r <= fo_latch_nxt;
         strap_r <= strap_nxt;
         strap_taken_r <= strap_taken_nxt;
         restart_r <= restart_nxt;
         soft_rst_r <= soft_rst_nxt;
         supply_r <= supply_nxt;
         fail_r <= fail_nxt;
      end
   end

   assign supply_ctl_o = supply_r;
   assign fail_ctl_o = fail_r;
   assign restart_req_o = restart_r;
   assign soft_reset_o = soft_rst_r;
endmodule
`default_nettype wire

// *** verilog/msh_reg_byte.sv ***
`timescale 1ns/1ps
`default_nettype none
module msh_reg_byte #(
   parameter logic [7:0] RST_VAL = 8'h00,
   parameter logic [7:0] KEEP_MASK = 8'h00,
   parameter logic [7:0] WR_MASK = 8'hff
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Load controls
   input wire logic load_por_i,
   input wire logic load_restart_i,
   input wire logic wr_en_i,
   input wire logic [7:0] wr_data_i,
   // Content
   output logic [7:0] q_o
);
   logic [7:0] q_r;
   logic [7:0] q_nxt;

   if ((RST_VAL & ~WR_MASK) != 8'h00) begin : g_chk
      $error("Reset value sets a read-only bit");
   end

   always_comb begin
      q_nxt = q_r;
      if (load_por_i) begin
         q_nxt = RST_VAL; // RL1
      end else if (load_restart_i) begin
         q_nxt = q_r & KEEP_MASK; // RL2
      end else if (wr_en_i) begin
         // Read-only bits ignore the write and stay zero
         q_nxt = wr_data_i & WR_MASK; // RL4
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q_r <= RST_VAL;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign q_o = q_r;
endmodule
`default_nettype wire

// *** verilog/msh_spi_frame.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "msh_defs.svh"
module msh_spi_frame import msh_pkg::*; (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Serial pins
   input wire logic csn_i,
   input wire logic sclk_i,
   input wire logic sdi_i,
   output logic sdo_o,
   // Register side
   input wire logic enable_i,
   input wire logic [7:0] status_i,
   input wire logic [7:0] rd_data_i,
   output logic [6:0] addr_o,
   output logic addr_valid_o,
   output msh_cmd_type cmd_o,
   output logic cmd_valid_o
);
   logic sclk_d_r, sclk_d_nxt;
   logic csn_d_r, csn_d_nxt;
   logic [4:0] cnt_r, cnt_nxt;
   logic [15:0] sh_r, sh_nxt;
   logic [7:0] stat_r, stat_nxt;
   logic [7:0] dat_r, dat_nxt;
   logic sdo_r, sdo_nxt;
   logic addr_valid_r, addr_valid_nxt;
   logic cmd_valid_r, cmd_valid_nxt;
   logic rise, fall, start, stop;

   always_comb begin
      rise = sclk_i & ~sclk_d_r;
      fall = ~sclk_i & sclk_d_r;
      start = ~csn_i & csn_d_r;
      stop = csn_i & ~csn_d_r;
      sclk_d_nxt = sclk_i;
      csn_d_nxt = csn_i;
      cnt_nxt = cnt_r;
      sh_nxt = sh_r;
      stat_nxt = stat_r;
      dat_nxt = dat_r;
      sdo_nxt = sdo_r;
      addr_valid_nxt = 1'b0;
      cmd_valid_nxt = 1'b0;
      if (start) begin
         cnt_nxt = 5'd0;
         stat_nxt = status_i;
         sdo_nxt = status_i[0];
      end else if (!csn_i) begin
         // Bit 0 first; 17 marks an overlong frame
         if (rise && cnt_r <= `MSH_FRAME_BITS) begin
            sh_nxt = {sdi_i, sh_r[15:1]}; // RL3
            cnt_nxt = cnt_r + 5'd1;
            addr_valid_nxt = enable_i && (cnt_r == `MSH_ADDR_BITS - 5'd1);
         end
         if (addr_valid_r) begin
            // Old content is captured before any write lands
            dat_nxt = rd_data_i; // RL23
         end
         if (fall && cnt_r < `MSH_FRAME_BITS) begin
            sdo_nxt = cnt_r[3] ? dat_r[cnt_r[2:0]] : stat_r[cnt_r[2:0]];
         end
      end
      if (stop) begin
         cmd_valid_nxt = enable_i && (cnt_r == `MSH_FRAME_BITS); // RL24
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sclk_d_r <= 1'b0;
         csn_d_r <= 1'b1;
         cnt_r <= 5'd0;
         sh_r <= 16'h0000;
         stat_r <= 8'h00;
         dat_r <= 8'h00;
         sdo_r <= 1'b0;
         addr_valid_r <= 1'b0;
         cmd_valid_r <= 1'b0;
      end else begin
         sclk_d_r <= sclk_d_nxt;
         csn_d_r <= csn_d_nxt;
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         stat_r <= stat_nxt;
         dat_r <= dat_nxt;
         sdo_r <= sdo_nxt;
         addr_valid_r <= addr_valid_nxt;
         cmd_valid_r <= cmd_valid_nxt;
      end
   end

   assign sdo_o = sdo_r;
   assign addr_o = sh_r[14:8];
   assign addr_valid_o = addr_valid_r;
   assign cmd_o = {sh_r[6:0], sh_r[7], sh_r[15:8]};
   assign cmd_valid_o = cmd_valid_r;
endmodule
`default_nettype wire
